// >>> rsq_clock_gen.v
// Oscillator source selection and the times-two doubler or divide-by-two core clock enable.
`timescale 1ns/1ps
`include "rsq_regs.vh"
module rsq_clock_gen (
	// Clock and reset
	input  wire       clk,
	input  wire       rst,
	// Oscillator ticks, one per source
	input  wire [5:0] oscTick,
	// Configuration
	input  wire [2:0] clockSource,
	input  wire       doublerEnable,
	// Outputs
	output wire       coreTick,
	output wire       doublerInRange,
	output wire [3:0] resonatorEnable
);
	// The bounds are worked out at full width, then cut to the width of the period counter.
	localparam [31:0] PMIN_W = `RSQ_DBL_PMIN;
	localparam [31:0] PMAX_W = `RSQ_DBL_PMAX;
	localparam [5:0]  PMIN   = PMIN_W[5:0];
	localparam [5:0]  PMAX   = PMAX_W[5:0];

	reg  [5:0] periodCnt;
	reg  [5:0] lastPeriod;
	reg        divPhase;
	wire       selTick;
	wire [5:0] halfPeriod;
	wire       midTick;

	assign selTick = (clockSource <= `RSQ_SRC_RC) ? oscTick[clockSource] : 1'b0;

	// Resonators follow only the source choice, never the reset phase.
	genvar i;
	generate
		for (i = 0; i < `RSQ_NUM_RES; i = i + 1) begin : gResonator
			assign resonatorEnable[i] = (clockSource == (`RSQ_SRC_RES0 + i));
		end
	endgenerate

	always @(posedge clk) begin
		if (rst) begin
			periodCnt  <= 6'h00;
			lastPeriod <= 6'h00;
			divPhase   <= 1'b0;
		end else if (selTick) begin
			periodCnt  <= 6'h00;
			lastPeriod <= periodCnt + 6'h01;
			divPhase   <= ~divPhase;
		end else if (periodCnt != 6'h3F) begin
			periodCnt <= periodCnt + 6'h01;
		end
	end

	// The measured period places a second tick halfway between oscillator ticks.
	assign halfPeriod = {1'b0, lastPeriod[5:1]};
	assign midTick = doublerEnable && !selTick && (halfPeriod != 6'h00) && (periodCnt + 6'h01 == halfPeriod);
	assign coreTick = doublerEnable ? (selTick | midTick) : (selTick & divPhase);
	assign doublerInRange = (lastPeriod >= PMIN) && (lastPeriod <= PMAX);
endmodule

// >>> rsq_ext_reset.sv
// Behavioural external reset circuit with the weak pull-up on the open-drain reset pin.
`timescale 1ns/1ps
module rsq_ext_reset (
	// Command from the bench
	input  logic pullLow,
	// Device side of the pin
	input  logic resetPinOut,
	input  logic resetPinDriveN,
	output logic pinLevel
);
	// The pull-up wins only while neither party sinks the line.
	assign pinLevel = (pullLow || (!resetPinDriveN && !resetPinOut)) ? 1'b0 : 1'b1;
endmodule

// >>> rsq_regs.vh
// Register offsets, field positions, reset values and timing counts of the reset sequencer.
`ifndef RSQ_REGS_VH
`define RSQ_REGS_VH

`define RSQ_AW            8
`define RSQ_ADDR_CONFIG   8'h00
`define RSQ_ADDR_STATUS   8'h04
`define RSQ_ADDR_FLAGS    8'h08

`define RSQ_SEL_NONE      2'h0
`define RSQ_SEL_CONFIG    2'h1
`define RSQ_SEL_STATUS    2'h2
`define RSQ_SEL_FLAGS     2'h3

`define RSQ_RESP_OKAY     2'h0
`define RSQ_RESP_SLVERR   2'h2

`define RSQ_CFG_DBL       0
`define RSQ_CFG_SRC_LO    1
`define RSQ_CFG_SRC_HI    3
`define RSQ_CFG_LONG      4
`define RSQ_CFG_RST_DBL   1'h0
`define RSQ_CFG_RST_SRC   3'h0
`define RSQ_CFG_RST_LONG  1'h1

`define RSQ_FL_EXT        0
`define RSQ_FL_LVD        1
`define RSQ_FL_WDG        2

`define RSQ_ST_PH_LO      0
`define RSQ_ST_PH_HI      1
`define RSQ_ST_PIN        2
`define RSQ_ST_RANGE      3
`define RSQ_ST_CPURST     4

`define RSQ_SRC_EXT       3'h0
`define RSQ_SRC_RES0      3'h1
`define RSQ_SRC_RC        3'h5
`define RSQ_NUM_RES       4
`define RSQ_NUM_SRC       6

`define RSQ_CLK_MHZ       40
`define RSQ_CLK_NS        25
`define RSQ_MIN_OUT_NS    20000
`define RSQ_MIN_OUT_CYC   ((`RSQ_MIN_OUT_NS + `RSQ_CLK_NS - 1) / `RSQ_CLK_NS)
`define RSQ_DELAY_SHORT   256
`define RSQ_DELAY_LONG    4096
`define RSQ_FETCH_CYC     2
`define RSQ_SETTLE_CYC    3
`define RSQ_VEC_LO        16'hFFFE
`define RSQ_VEC_HI        16'hFFFF
`define RSQ_DBL_FMIN_MHZ  2
`define RSQ_DBL_FMAX_MHZ  4
`define RSQ_DBL_PMAX      (`RSQ_CLK_MHZ / `RSQ_DBL_FMIN_MHZ)
`define RSQ_DBL_PMIN      (`RSQ_CLK_MHZ / `RSQ_DBL_FMAX_MHZ)

`endif

// >>> rsq_reset_seq.v
// Reset sequence manager with its AXI4-Lite configuration and status registers.
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "rsq_regs.vh"
// Functional notes
// - Doubler enabled with 2 to 4 MHz input yields twice the input frequency.
// - Doubler disabled: core clock is the oscillator clock divided by two.
// - Configuration chooses external clock, one of four resonators, or internal RC.
// - Resonator oscillators keep running through the whole reset phase.
// - Reset pin, low voltage and watchdog underflow all start reset and drive the pin.
// - Reset pin is held low for the entire stabilisation delay.
// - Stabilisation delay lasts 256 or 4096 CPU cycles, chosen by configuration.
// - Reset vector is fetched from addresses FFFE and FFFF.
// - Vector fetch phase lasts exactly two CPU cycles.
// - A low reset pin is caught without needing a running clock.
// - A recognised external pulse is stretched to the minimum output width.
// - Watchdog underflow drives the pin low for at least the minimum width.
// - Pin is driven low while the low-voltage detector reports a low supply.
// - Reset pin is open-drain: device only ever drives it low.
// - Sequence runs active phase, then stabilisation delay, then vector fetch.
module rsq_reset_seq (
	// Clock and reset
	input  wire                clk,
	input  wire                rst,
	// AXI4-Lite write address and data
	input  wire                s_axi_awvalid,
	output wire                s_axi_awready,
	input  wire [`RSQ_AW-1:0]  s_axi_awaddr,
	input  wire                s_axi_wvalid,
	output wire                s_axi_wready,
	input  wire [31:0]         s_axi_wdata,
	input  wire [3:0]          s_axi_wstrb,
	// AXI4-Lite write response
	output reg                 s_axi_bvalid,
	input  wire                s_axi_bready,
	output reg  [1:0]          s_axi_bresp,
	// AXI4-Lite read
	input  wire                s_axi_arvalid,
	output wire                s_axi_arready,
	input  wire [`RSQ_AW-1:0]  s_axi_araddr,
	output reg                 s_axi_rvalid,
	input  wire                s_axi_rready,
	output reg  [31:0]         s_axi_rdata,
	output reg  [1:0]          s_axi_rresp,
	// Open-drain reset pin
	input  wire                resetPinIn,
	output wire                resetPinOut,
	output wire                resetPinDriveN,
	// Internal reset sources
	input  wire                lowVoltage,
	input  wire                watchdogUnderflow,
	// Oscillators
	input  wire [5:0]          oscTick,
	output wire [3:0]          resonatorEnable,
	output wire                coreTick,
	// CPU side
	output reg                 cpuReset,
	output reg                 vectorFetch,
	output reg  [15:0]         vectorAddr
);
	localparam [1:0]  PH_RUN     = 2'h0;
	localparam [1:0]  PH_ACTIVE  = 2'h1;
	localparam [1:0]  PH_DELAY   = 2'h2;
	localparam [1:0]  PH_FETCH   = 2'h3;
	// Counts are worked out at full width first, then cut to the width of the counters that use them.
	localparam [31:0] WIDTH_LAST_W = `RSQ_MIN_OUT_CYC - 1;
	localparam [31:0] SHORT_LAST_W = `RSQ_DELAY_SHORT - 1;
	localparam [31:0] LONG_LAST_W  = `RSQ_DELAY_LONG - 1;
	localparam [31:0] FETCH_LAST_W = `RSQ_FETCH_CYC - 1;
	localparam [31:0] SETTLE_END_W = `RSQ_SETTLE_CYC;
	localparam [12:0] WIDTH_LAST   = WIDTH_LAST_W[12:0];
	localparam [12:0] SHORT_LAST   = SHORT_LAST_W[12:0];
	localparam [12:0] LONG_LAST    = LONG_LAST_W[12:0];
	localparam [12:0] FETCH_LAST   = FETCH_LAST_W[12:0];
	localparam [1:0]  SETTLE_END   = SETTLE_END_W[1:0];

	// Sequencer state.
	reg  [1:0]  phase;
	reg  [12:0] widthCnt;
	reg  [12:0] delayCnt;
	reg  [1:0]  settleCnt;
	reg  [1:0]  next_phase;
	reg  [12:0] next_widthCnt;
	reg  [12:0] next_delayCnt;
	reg  [1:0]  next_settleCnt;
	reg         pinDrive;

	// Configuration and sticky cause flags.
	reg         cfgDoubler;
	reg  [2:0]  cfgSource;
	reg         cfgLongDelay;
	reg         flagExt;
	reg         flagLvd;
	reg         flagWdg;
	reg  [31:0] cfgWord;
	reg  [31:0] statusWord;
	reg  [31:0] flagWord;

	// Bus write holding state.
	reg                awHeld;
	reg                wHeld;
	reg  [`RSQ_AW-1:0] awAddr;
	reg  [31:0]        wData;
	reg  [3:0]         wStrb;

	wire        pinReq;
	wire        inRange;
	wire        extReq;
	wire        restart;
	wire [12:0] delayLast;
	wire        doWrite;
	wire [1:0]  wrSel;
	wire [1:0]  rdSel;
	wire        clrExt;
	wire        clrLvd;
	wire        clrWdg;
	wire        flagWrite;

	function [1:0] decodeAddr;
		input [`RSQ_AW-1:0] addr;
		begin
			case (addr)
				`RSQ_ADDR_CONFIG: decodeAddr = `RSQ_SEL_CONFIG;
				`RSQ_ADDR_STATUS: decodeAddr = `RSQ_SEL_STATUS;
				`RSQ_ADDR_FLAGS:  decodeAddr = `RSQ_SEL_FLAGS;
				default:          decodeAddr = `RSQ_SEL_NONE;
			endcase
		end
	endfunction

	rsq_sync uSync (
		.clk    (clk),
		.rst    (rst),
		.pinIn  (resetPinIn),
		.pinReq (pinReq)
	);

	rsq_clock_gen uClock (
		.clk             (clk),
		.rst             (rst),
		.oscTick         (oscTick),
		.clockSource     (cfgSource),
		.doublerEnable   (cfgDoubler),
		.coreTick        (coreTick),
		.doublerInRange  (inRange),
		.resonatorEnable (resonatorEnable)
	);

	// While the device drives the pin, its own low level must not count as a new external reset, and
	// after release the synchroniser still carries that level for a few cycles, hence the settle wait.
	assign extReq = pinReq && (phase == PH_RUN) && (settleCnt == SETTLE_END);
	assign restart = extReq | watchdogUnderflow | lowVoltage;
	assign delayLast = cfgLongDelay ? LONG_LAST : SHORT_LAST;

	always @* begin
		next_phase     = phase;
		next_widthCnt  = widthCnt;
		next_delayCnt  = delayCnt;
		next_settleCnt = settleCnt;
		if (restart) begin
			// Any source restarts the active phase, so the minimum width counts from the last event.
			next_phase    = PH_ACTIVE;
			next_widthCnt = 13'h0000;
			next_delayCnt = 13'h0000;
		end else begin
			case (phase)
				PH_ACTIVE: begin
					if (widthCnt == WIDTH_LAST) begin
						next_phase    = PH_DELAY;
						next_delayCnt = 13'h0000;
					end else begin
						next_widthCnt = widthCnt + 13'h0001;
					end
				end
				PH_DELAY: begin
					if (coreTick) begin
						if (delayCnt == delayLast) begin
							next_phase    = PH_FETCH;
							next_delayCnt = 13'h0000;
						end else begin
							next_delayCnt = delayCnt + 13'h0001;
						end
					end
				end
				PH_FETCH: begin
					if (coreTick) begin
						if (delayCnt == FETCH_LAST) begin
							next_phase     = PH_RUN;
							next_settleCnt = 2'h0;
						end else begin
							next_delayCnt = delayCnt + 13'h0001;
						end
					end
				end
				PH_RUN: begin
					if (settleCnt != SETTLE_END)
						next_settleCnt = settleCnt + 2'h1;
				end
				default: begin
					next_phase = PH_ACTIVE;
				end
			endcase
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			phase       <= PH_ACTIVE;
			widthCnt    <= 13'h0000;
			delayCnt    <= 13'h0000;
			settleCnt   <= 2'h0;
			pinDrive    <= 1'b1;
			cpuReset    <= 1'b1;
			vectorFetch <= 1'b0;
			vectorAddr  <= 16'h0000;
		end else begin
			phase       <= next_phase;
			widthCnt    <= next_widthCnt;
			delayCnt    <= next_delayCnt;
			settleCnt   <= next_settleCnt;
			pinDrive    <= (next_phase == PH_ACTIVE) || (next_phase == PH_DELAY);
			cpuReset    <= (next_phase != PH_RUN);
			vectorFetch <= (next_phase == PH_FETCH);
			if (next_phase == PH_FETCH)
				vectorAddr <= (next_delayCnt == 13'h0000) ? `RSQ_VEC_LO : `RSQ_VEC_HI;
			else
				vectorAddr <= 16'h0000;
		end
	end

	// The pin is only ever pulled low; the weak pull-up outside supplies the high level.
	assign resetPinOut = 1'b0;
	assign resetPinDriveN = ~pinDrive;

	// Write channel: address and data are taken independently and held until both are present.
	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready = !wHeld && !s_axi_bvalid;
	assign doWrite = awHeld && wHeld && !s_axi_bvalid;
	assign wrSel = decodeAddr(awAddr);

	always @(posedge clk) begin
		if (rst) begin
			awHeld       <= 1'b0;
			wHeld        <= 1'b0;
			awAddr       <= {`RSQ_AW{1'b0}};
			wData        <= 32'h00000000;
			wStrb        <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RSQ_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeld       <= 1'b0;
				wHeld        <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wrSel == `RSQ_SEL_NONE) ? `RSQ_RESP_SLVERR : `RSQ_RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Configuration lives in byte lane 0; a changed delay choice applies at once, also to a delay count in progress.
	always @(posedge clk) begin
		if (rst) begin
			cfgDoubler   <= `RSQ_CFG_RST_DBL;
			cfgSource    <= `RSQ_CFG_RST_SRC;
			cfgLongDelay <= `RSQ_CFG_RST_LONG;
		end else if (doWrite && (wrSel == `RSQ_SEL_CONFIG) && wStrb[0]) begin
			cfgDoubler   <= wData[`RSQ_CFG_DBL];
			cfgSource    <= wData[`RSQ_CFG_SRC_HI:`RSQ_CFG_SRC_LO];
			cfgLongDelay <= wData[`RSQ_CFG_LONG];
		end
	end

	// Cause flags clear on a written one; a cause in the same cycle keeps its flag set.
	assign flagWrite = doWrite && (wrSel == `RSQ_SEL_FLAGS) && wStrb[0];
	assign clrExt = flagWrite && wData[`RSQ_FL_EXT];
	assign clrLvd = flagWrite && wData[`RSQ_FL_LVD];
	assign clrWdg = flagWrite && wData[`RSQ_FL_WDG];

	always @(posedge clk) begin
		if (rst) begin
			flagExt <= 1'b0;
			flagLvd <= 1'b0;
			flagWdg <= 1'b0;
		end else begin
			flagExt <= (flagExt & ~clrExt) | extReq;
			flagLvd <= (flagLvd & ~clrLvd) | lowVoltage;
			flagWdg <= (flagWdg & ~clrWdg) | watchdogUnderflow;
		end
	end

	// Read words are built bit by bit so that every field sits where the header places it.
	always @* begin
		cfgWord = 32'h00000000;
		cfgWord[`RSQ_CFG_DBL] = cfgDoubler;
		cfgWord[`RSQ_CFG_SRC_HI:`RSQ_CFG_SRC_LO] = cfgSource;
		cfgWord[`RSQ_CFG_LONG] = cfgLongDelay;
		statusWord = 32'h00000000;
		statusWord[`RSQ_ST_PH_HI:`RSQ_ST_PH_LO] = phase;
		statusWord[`RSQ_ST_PIN] = resetPinIn;
		statusWord[`RSQ_ST_RANGE] = inRange;
		statusWord[`RSQ_ST_CPURST] = cpuReset;
		flagWord = 32'h00000000;
		flagWord[`RSQ_FL_EXT] = flagExt;
		flagWord[`RSQ_FL_LVD] = flagLvd;
		flagWord[`RSQ_FL_WDG] = flagWdg;
	end

	// Read channel: one read at a time, answered one cycle after the address is taken.
	assign s_axi_arready = !s_axi_rvalid;
	assign rdSel = decodeAddr(s_axi_araddr);

	always @(posedge clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `RSQ_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `RSQ_RESP_OKAY;
			case (rdSel)
				`RSQ_SEL_CONFIG: s_axi_rdata <= cfgWord;
				`RSQ_SEL_STATUS: s_axi_rdata <= statusWord;
				`RSQ_SEL_FLAGS:  s_axi_rdata <= flagWord;
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `RSQ_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// >>> rsq_reset_seq_chk.sv
// Concurrent checks on the reset pin and CPU outputs of the reset sequencer.
`timescale 1ns/1ps
module rsq_reset_seq_chk (
	// Clock and reset
	input logic        clk,
	input logic        rst,
	// Reset sources and pin
	input logic        watchdogUnderflow,
	input logic        lowVoltage,
	input logic        resetPinIn,
	input logic        resetPinOut,
	input logic        resetPinDriveN,
	// CPU side
	input logic        coreTick,
	input logic        cpuReset,
	input logic        vectorFetch,
	input logic [15:0] vectorAddr
);
	// Counts cycles of own pin drive; 16 bits outlast any sequence the bench runs.
	logic [15:0] lowCnt;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	always @(posedge clk) begin
		if (rst || resetPinDriveN)
			lowCnt <= 16'h0000;
		else
			lowCnt <= lowCnt + 16'h0001;
	end
	pin_open_a: assert property (resetPinOut == 1'b0)
		else $error("reset pin output not low");
	wdg_drive_a: assert property (watchdogUnderflow |=> !resetPinDriveN && cpuReset)
		else $error("watchdog did not drive the pin");
	lvd_drive_a: assert property (lowVoltage |=> !resetPinDriveN && cpuReset)
		else $error("low supply did not drive the pin");
	delay_hold_a: assert property (cpuReset && !vectorFetch |-> !resetPinDriveN)
		else $error("pin released before vector fetch");
	min_width_a: assert property ($rose(resetPinDriveN) |-> lowCnt >= 16'h0320)
		else $error("pin drive shorter than minimum width");
	fetch_lo_a: assert property ($rose(vectorFetch) |-> vectorAddr == 16'hFFFE && resetPinDriveN)
		else $error("fetch did not start at low vector word");
	fetch_hi_a: assert property (vectorFetch && vectorAddr == 16'hFFFE && coreTick && !watchdogUnderflow && !lowVoltage
		|=> vectorFetch && vectorAddr == 16'hFFFF)
		else $error("second vector word missing");
	fetch_end_a: assert property (vectorAddr == 16'hFFFF && coreTick && !watchdogUnderflow && !lowVoltage
		|=> !vectorFetch && !cpuReset)
		else $error("run did not follow the fetch");
	pin_catch_a: assert property (!cpuReset [*4] ##1 (!cpuReset && $fell(resetPinIn)) |-> ##[1:5] !resetPinDriveN)
		else $error("low pin not caught in run");
endmodule

bind rsq_reset_seq rsq_reset_seq_chk rsq_reset_seq_chk_inst (.clk, .rst, .watchdogUnderflow, .lowVoltage,
	.resetPinIn, .resetPinOut, .resetPinDriveN, .coreTick, .cpuReset, .vectorFetch, .vectorAddr);

// >>> rsq_reset_seq_tb_top.sv
// Self-checking bench for the reset sequencer, its register bus and its reset pin.
`timescale 1ns/1ps
module rsq_reset_seq_tb_top;
	// Bench-driven inputs
	logic        clk, rst, lowVoltage, watchdogUnderflow, pullLow;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [5:0]  oscTick;
	logic [1:0]  rsp;
	// Design outputs
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	wire         resetPinIn, resetPinOut, resetPinDriveN, coreTick, cpuReset, vectorFetch;
	wire  [3:0]  resonatorEnable;
	wire  [15:0] vectorAddr;
	int          fails, totalChecks, period, tickCnt, n, s;
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// All sources tick together, so any selected source sees the same rate.
	always @(posedge clk) begin
		if (rst) begin
			tickCnt <= 0;
			oscTick <= 6'h00;
		end else begin
			tickCnt <= (tickCnt >= period - 1) ? 0 : tickCnt + 1;
			oscTick <= (tickCnt >= period - 1) ? 6'h3F : 6'h00;
		end
	end
	rsq_reset_seq rsq_reset_seq_inst (.clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
		.s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
		.s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .resetPinIn,
		.resetPinOut, .resetPinDriveN, .lowVoltage, .watchdogUnderflow, .oscTick, .resonatorEnable, .coreTick,
		.cpuReset, .vectorFetch, .vectorAddr);
	rsq_ext_reset rsq_ext_reset_inst (.pullLow, .resetPinOut, .resetPinDriveN, .pinLevel(resetPinIn));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task endSim;
		$display("Checks %0d, mismatches %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task tmo;
		$display("BAD at %0t: wait ran out", $time);
		fails++;
		endSim;
	endtask
	task axW(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int k;
		logic ta, tw, done;
		@(posedge clk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_bready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(negedge clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			done = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			if (done)
				break;
		end
		s_axi_bready <= 1'b0;
		if (k == 50)
			tmo;
	endtask
	task axR(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int k;
		logic ta, done;
		@(posedge clk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(negedge clk);
			ta = s_axi_arvalid && s_axi_arready;
			done = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk);
			if (ta)
				s_axi_arvalid <= 1'b0;
			if (done)
				break;
		end
		s_axi_rready <= 1'b0;
		if (k == 50)
			tmo;
	endtask
	// Counts CPU ticks up to the fetch, then checks the fetch itself and the return to run.
	task runSeq(input int nDelay, input int nActive);
		int c;
		n = 0;
		for (c = 0; c < 20000; c++) begin
			@(negedge clk);
			if (vectorFetch)
				break;
			n += coreTick;
		end
		if (c == 20000)
			tmo;
		chk(n >= nActive + nDelay - 3 && n <= nActive + nDelay + 3, 32'h1);
		chk(vectorAddr, 32'hFFFE);
		chk(resetPinDriveN, 32'h1);
		n = 0;
		for (c = 0; c < 100 && vectorFetch; c++) begin
			n += coreTick;
			@(negedge clk);
		end
		chk(n, 32'h2);
		chk(cpuReset, 32'h0);
	endtask
	task tPowerOn;
		runSeq(4096, 400);
		axR(8'h00, rd, rsp);
		chk(rd, 32'h10);
		axR(8'h04, rd, rsp);
		chk(rd, 32'h4);
	endtask
	task tWatchdog;
		axW(8'h00, 32'h2, rsp);
		@(posedge clk);
		watchdogUnderflow <= 1'b1;
		@(posedge clk);
		watchdogUnderflow <= 1'b0;
		@(negedge clk);
		chk(resetPinDriveN, 32'h0);
		chk(resonatorEnable, 32'h1);
		runSeq(256, 400);
	endtask
	task tLowVolt;
		@(posedge clk);
		lowVoltage <= 1'b1;
		repeat (1000) @(posedge clk);
		lowVoltage <= 1'b0;
		@(negedge clk);
		chk(resetPinIn, 32'h0);
		runSeq(256, 400);
	endtask
	task tExtPin;
		repeat (6) @(posedge clk);
		pullLow <= 1'b1;
		repeat (5) @(posedge clk);
		pullLow <= 1'b0;
		repeat (20) @(negedge clk);
		chk(resetPinIn, 32'h0);
		runSeq(256, 389);
	endtask
	task tRegs;
		axR(8'h08, rd, rsp);
		chk(rd, 32'h7);
		axW(8'h08, 32'h7, rsp);
		axR(8'h08, rd, rsp);
		chk(rd, 32'h0);
		axR(8'h0C, rd, rsp);
		chk(rsp, 32'h2);
		chk(rd, 32'h0);
		axW(8'h0C, 32'h0, rsp);
		chk(rsp, 32'h2);
		axW(8'h04, 32'h1F, rsp);
		axR(8'h04, rd, rsp);
		chk(rsp, 32'h0);
		chk(rd, 32'h4);
	endtask
	task tClock;
		for (s = 0; s < 6; s++) begin
			axW(8'h00, s << 1, rsp);
			chk(resonatorEnable, (s >= 1 && s <= 4) ? (1 << (s - 1)) : 0);
		end
		period = 16;
		axW(8'h00, 32'h3, rsp);
		repeat (100) @(posedge clk);
		n = 0;
		repeat (320) @(negedge clk) n += coreTick;
		chk(n >= 39 && n <= 41, 32'h1);
		axR(8'h04, rd, rsp);
		chk(rd[3], 32'h1);
		axW(8'h00, 32'h2, rsp);
		repeat (50) @(posedge clk);
		n = 0;
		repeat (320) @(negedge clk) n += coreTick;
		chk(n >= 9 && n <= 11, 32'h1);
	endtask
	initial begin
		rst = 1'b1;
		lowVoltage = 1'b0;
		watchdogUnderflow = 1'b0;
		pullLow = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		period = 1;
		fails = 0;
		totalChecks = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		pullLow <= 1'b0;
		tPowerOn;
		tWatchdog;
		tLowVolt;
		tExtPin;
		tRegs;
		tClock;
		endSim;
	end
endmodule

// >>> rsq_sync.v
// Asynchronous catch of a low reset pin and its synchroniser into the core clock.
`timescale 1ns/1ps
module rsq_sync (
	// Clock and reset
	input  wire clk,
	input  wire rst,
	// Pin level and synchronised request
	input  wire pinIn,
	output wire pinReq
);
	reg catchFf;
	reg syncA;
	reg syncB;

	// A low pin sets the catch without a clock edge, so a halted clock cannot hide it.
	always @(posedge clk or negedge pinIn) begin
		if (!pinIn)
			catchFf <= 1'b1;
		else
			catchFf <= 1'b0;
	end

	always @(posedge clk) begin
		if (rst) begin
			syncA <= 1'b0;
			syncB <= 1'b0;
		end else begin
			syncA <= catchFf;
			syncB <= syncA;
		end
	end

	assign pinReq = syncB;
endmodule
